// ==== hdl/sdpc_pkg.sv ====
// package: constants and carriers for the sdram pin command interface
package sdpc_pkg;
	localparam int ROW_W       = 11;
	localparam int COL_W       = 8;
	localparam int DATA_W      = 16;
	localparam int READ_MASK_LAT = 2;
	localparam int CAS_LAT     = 2;
	localparam int BURST_LEN   = 4;
	localparam int BANKS       = 2;
	localparam logic [7:0] RST_COUNT = 8'h00;

	typedef enum logic [2:0] {
		SDPC_CMD_NOP,
		SDPC_CMD_ACT,
		SDPC_CMD_READ,
		SDPC_CMD_WRITE,
		SDPC_CMD_PRE,
		SDPC_CMD_REF,
		SDPC_CMD_MRS,
		SDPC_CMD_STOP
	} sdpc_cmd_e;

	typedef enum logic [1:0] {
		SDPC_ST_RUN,
		SDPC_ST_PDOWN,
		SDPC_ST_SUSP,
		SDPC_ST_SREF
	} sdpc_pwr_e;

	// sampled pin inputs
	typedef struct packed {
		logic              cs_n;
		logic              ras_n;
		logic              cas_n;
		logic              we_n;
		logic              bank;
		logic [10:0]       address_lines;
		logic              upper_byte_mask;
		logic              lower_byte_mask;
	} sdpc_pins_s;

	// write request towards the array
	typedef struct packed {
		logic              en;
		logic              bank;
		logic [10:0]       row;
		logic [7:0]        col;
		logic [1:0]        byte_en;
		logic [15:0]       data;
	} sdpc_wr_s;
endpackage

// ==== hdl/sdpc_core.sv ====
// sdram pin command decoder, address mux, byte masks and power states
// Behaviour
// - row on all lines, column on low eight
// - bank input picks activated or accessed bank
// - deselected decoder ignores commands, operation continues
// - command from row, column, write strobes
// - read mask drives data high impedance after two
// - write mask blocks same cycle write
// - all inputs sampled on rising clock edge
// - clock enable low enters low power state
// - sixteen shared data lines, device drives reads
// - upper and lower masks control own bytes
`timescale 1ns/1ps
module sdpc_core
	import sdpc_pkg::*;
#(
	parameter int DATA_WIDTH = DATA_W
) (
	input  wire logic                  clk,             // system clock
	input  wire logic                  rst,             // sync reset
	input  wire logic                  clock_enable,    // low: suspend etc
	input  wire sdpc_pins_s            pins,            // command pins
	input  wire logic [DATA_WIDTH-1:0] data_lines_in,   // data pin level
	output logic      [DATA_WIDTH-1:0] data_lines_out,  // read data
	output logic      [DATA_WIDTH-1:0] data_lines_oe,   // drive per bit
	output sdpc_wr_s                   array_write,     // write to array
	output logic      [ROW_W-1:0]      array_read_row,  // read row
	output logic      [COL_W-1:0]      array_read_col,  // read column
	output logic                       array_read_bank, // read bank
	output logic                       array_read_en,   // read strobe
	input  wire logic [DATA_WIDTH-1:0] array_read_data, // data from array
	output sdpc_pwr_e                  power_state,     // low power state
	output logic      [BANKS-1:0]      bank_open        // bank active flags
);
	function automatic sdpc_cmd_e decode(input sdpc_pins_s p);
		case ({p.ras_n, p.cas_n, p.we_n})
			3'h3: decode = SDPC_CMD_ACT;
			3'h5: decode = SDPC_CMD_READ;
			3'h4: decode = SDPC_CMD_WRITE;
			3'h2: decode = SDPC_CMD_PRE;
			3'h1: decode = SDPC_CMD_REF;
			3'h0: decode = SDPC_CMD_MRS;
			3'h6: decode = SDPC_CMD_STOP;
			default: decode = SDPC_CMD_NOP;
		endcase
	endfunction

	sdpc_pwr_e            pwr, next_pwr;
	logic [ROW_W-1:0]     row_of [BANKS], next_row_of [BANKS];
	logic [BANKS-1:0]     open_b, next_open_b;
	logic                 rd_act, next_rd_act, wr_act, next_wr_act;
	logic [7:0]           left, next_left;
	logic [COL_W-1:0]     col, next_col;
	logic                 bk, next_bk;
	logic [CAS_LAT-1:0]   rd_pipe, next_rd_pipe;
	logic [1:0]           m1, next_m1;
	logic [DATA_WIDTH-1:0] dout, next_dout, doe, next_doe;
	sdpc_wr_s             wr, next_wr;
	logic                 rden, next_rden;
	sdpc_cmd_e            cmd;
	logic                 run;
	logic [1:0]           mask_now;

	always_comb begin
		run = clock_enable && (pwr == SDPC_ST_RUN);
		cmd = (run && !pins.cs_n) ? decode(pins) : SDPC_CMD_NOP;
		mask_now = {pins.upper_byte_mask, pins.lower_byte_mask};
		next_pwr = pwr;
		next_open_b = open_b;
		for (int b = 0; b < BANKS; b++) begin
			next_row_of[b] = row_of[b];
		end
		next_rd_act = rd_act;
		next_wr_act = wr_act;
		next_left = left;
		next_col = col;
		next_bk = bk;
		next_rd_pipe = rd_pipe;
		next_m1 = m1;
		next_dout = dout;
		next_doe = doe;
		next_wr = '0;
		next_rden = 1'b0;
		// context picks the low power state
		if (!clock_enable && pwr == SDPC_ST_RUN) begin
			if (!pins.cs_n && decode(pins) == SDPC_CMD_REF)
				next_pwr = SDPC_ST_SREF;
			else if (rd_act || wr_act)
				next_pwr = SDPC_ST_SUSP;
			else
				next_pwr = SDPC_ST_PDOWN;
		end else if (clock_enable && pwr != SDPC_ST_RUN) begin
			next_pwr = SDPC_ST_RUN;
		end
		if (run) begin
			// burst engine continues regardless of chip select
			if (rd_act || wr_act) begin
				next_col = col + 8'h01;
				next_left = left - 8'h01;
				if (left == 8'h01) begin
					next_rd_act = 1'b0;
					next_wr_act = 1'b0;
				end
			end
			case (cmd)
				SDPC_CMD_ACT: begin
					next_open_b[pins.bank] = 1'b1;
					next_row_of[pins.bank] = pins.address_lines;
				end
				SDPC_CMD_READ, SDPC_CMD_WRITE: begin
					next_bk = pins.bank;
					next_col = pins.address_lines[COL_W-1:0] + 8'h01;
					next_left = 8'(BURST_LEN - 1);
					next_rd_act = (cmd == SDPC_CMD_READ) && (BURST_LEN > 1);
					next_wr_act = (cmd == SDPC_CMD_WRITE) && (BURST_LEN > 1);
				end
				SDPC_CMD_PRE: begin
					if (pins.address_lines[10])
						next_open_b = '0;
					else
						next_open_b[pins.bank] = 1'b0;
				end
				SDPC_CMD_STOP: begin
					next_rd_act = 1'b0;
					next_wr_act = 1'b0;
				end
				default: ;
			endcase
			// first data with the command, rest each edge
			if (cmd == SDPC_CMD_WRITE || (wr_act && cmd != SDPC_CMD_READ
					&& cmd != SDPC_CMD_STOP)) begin
				next_wr.en = 1'b1;
				next_wr.bank = (cmd == SDPC_CMD_WRITE) ? pins.bank : bk;
				next_wr.col = (cmd == SDPC_CMD_WRITE) ?
					pins.address_lines[COL_W-1:0] : col;
				next_wr.row = row_of[next_wr.bank];
				next_wr.byte_en = ~mask_now;
				next_wr.data = data_lines_in;
			end
			if (cmd == SDPC_CMD_READ || (rd_act && cmd != SDPC_CMD_WRITE
					&& cmd != SDPC_CMD_STOP)) begin
				next_rden = 1'b1;
			end
			// read data pipe of cas latency
			next_rd_pipe = {rd_pipe[CAS_LAT-2:0], rden};
			next_m1 = mask_now;
			next_dout = array_read_data;
			for (int i = 0; i < DATA_WIDTH; i++) begin
				next_doe[i] = rd_pipe[CAS_LAT-2]
					&& !m1[i / (DATA_WIDTH / 2)];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pwr <= SDPC_ST_RUN;
			open_b <= '0;
			for (int b = 0; b < BANKS; b++) begin
				row_of[b] <= '0;
			end
			rd_act <= 1'b0;
			wr_act <= 1'b0;
			left <= RST_COUNT;
			col <= '0;
			bk <= 1'b0;
			rd_pipe <= '0;
			m1 <= '0;
			dout <= '0;
			doe <= '0;
			wr <= '0;
			rden <= 1'b0;
		end else begin
			pwr <= next_pwr;
			open_b <= next_open_b;
			row_of <= next_row_of;
			rd_act <= next_rd_act;
			wr_act <= next_wr_act;
			left <= next_left;
			col <= next_col;
			bk <= next_bk;
			rd_pipe <= next_rd_pipe;
			m1 <= next_m1;
			dout <= next_dout;
			doe <= next_doe;
			wr <= next_wr;
			rden <= next_rden;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			array_read_row <= '0;
			array_read_col <= '0;
			array_read_bank <= 1'b0;
		end else if (next_rden) begin
			array_read_bank <= (cmd == SDPC_CMD_READ) ? pins.bank : bk;
			array_read_col <= (cmd == SDPC_CMD_READ) ?
				pins.address_lines[COL_W-1:0] : col;
			array_read_row <= (cmd == SDPC_CMD_READ) ?
				row_of[pins.bank] : row_of[bk];
		end
	end

	assign data_lines_out = dout;
	assign data_lines_oe = doe;
	assign array_write = wr;
	assign array_read_en = rden;
	assign power_state = pwr;
	assign bank_open = open_b;

	a_cs_ignore: assert property (@(posedge clk) disable iff (rst)
		(pins.cs_n && clock_enable && pwr == SDPC_ST_RUN && !wr_act)
		|=> !array_write.en) else $error("write taken while deselected");
	a_write_mask: assert property (@(posedge clk) disable iff (rst)
		(run && !pins.cs_n && decode(pins) == SDPC_CMD_WRITE)
		|=> array_write.en && array_write.byte_en == ~$past(mask_now))
		else $error("write mask not applied");
	a_read_mask: assert property (@(posedge clk) disable iff (rst)
		(run && pins.lower_byte_mask) ##1 run |=> !data_lines_oe[0])
		else $error("masked read byte driven");
	a_row_latch: assert property (@(posedge clk) disable iff (rst)
		(run && !pins.cs_n && decode(pins) == SDPC_CMD_ACT)
		|=> bank_open[$past(pins.bank)])
		else $error("bank not opened");
	a_pdown_entry: assert property (@(posedge clk) disable iff (rst)
		(!clock_enable && pwr == SDPC_ST_RUN) |=> power_state != SDPC_ST_RUN)
		else $error("low power not entered");
	a_read_start: assert property (@(posedge clk) disable iff (rst)
		(run && !pins.cs_n && decode(pins) == SDPC_CMD_READ)
		|=> array_read_en
		&& array_read_col == $past(pins.address_lines[COL_W-1:0]))
		else $error("read column not latched");
endmodule // sdpc_core

// ==== dv/sdpc_ctrl_model.sv ====
// controller model: command strobes, masks and shared data bus level
`timescale 1ns/1ps
module sdpc_ctrl_model
	import sdpc_pkg::*;
(
	input  wire sdpc_cmd_e   cmd,     // command to send
	input  wire logic        desel,   // chip select off
	input  wire logic        bank,    // bank select
	input  wire logic [10:0] addr,    // address lines
	input  wire logic [1:0]  mask,    // upper, lower mask
	input  wire logic        wdrive,  // controller drives data
	input  wire logic [15:0] wdata,   // write data
	input  wire logic [15:0] dev_out, // device data
	input  wire logic [15:0] dev_oe,  // device drive
	output sdpc_pins_s       pins,    // pins to device
	output logic      [15:0] level    // resolved bus level
);
	logic [2:0] strb;
	always_comb begin
		case (cmd)
			SDPC_CMD_ACT:   strb = 3'h3;
			SDPC_CMD_READ:  strb = 3'h5;
			SDPC_CMD_WRITE: strb = 3'h4;
			SDPC_CMD_PRE:   strb = 3'h2;
			SDPC_CMD_REF:   strb = 3'h1;
			SDPC_CMD_MRS:   strb = 3'h0;
			SDPC_CMD_STOP:  strb = 3'h6;
			default:        strb = 3'h7;
		endcase
		pins.cs_n = desel;
		{pins.ras_n, pins.cas_n, pins.we_n} = strb;
		pins.bank = bank;
		pins.address_lines = addr;
		{pins.upper_byte_mask, pins.lower_byte_mask} = mask;
	end
	// released lines show the inverse of the current wdata input
	assign level = (dev_oe & dev_out) | (~dev_oe & (wdrive ? wdata : ~wdata));
endmodule // sdpc_ctrl_model

// ==== dv/tb_top.sv ====
// testbench for the sdram pin command interface
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
	mismatches++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top
	import sdpc_pkg::*;
;
	logic        clk = 0, rst = 1, cke = 1, desel = 0, bank = 0, wdrive = 0;
	logic        b, rbank, ren;
	sdpc_cmd_e   cmd = SDPC_CMD_NOP;
	logic [10:0] addr = '0, rrow;
	logic [1:0]  mask = '0, m, bopen;
	logic [7:0]  c, rcol;
	logic [15:0] wdata = '0, rd_q = '0, d, e, level, dout, doe;
	sdpc_pins_s  pins;
	sdpc_wr_s    aw;
	sdpc_pwr_e   pst;
	int          mismatches = 0, checks = 0;
	// bank, column, masks, data
	logic [26:0] rows [4] = '{{1'h0, 8'h00, 2'h0, 16'h1234},
		{1'h1, 8'hff, 2'h1, 16'hbeef}, {1'h0, 8'h7e, 2'h2, 16'h0f0f},
		{1'h1, 8'h81, 2'h3, 16'ha5a5}};
	sdpc_ctrl_model ctrl (.cmd(cmd), .desel(desel), .bank(bank), .addr(addr),
		.mask(mask), .wdrive(wdrive), .wdata(wdata), .dev_out(dout),
		.dev_oe(doe), .pins(pins), .level(level));
	sdpc_core uut (.clk(clk), .rst(rst), .clock_enable(cke), .pins(pins),
		.data_lines_in(level), .data_lines_out(dout), .data_lines_oe(doe),
		.array_write(aw), .array_read_row(rrow), .array_read_col(rcol),
		.array_read_bank(rbank), .array_read_en(ren), .array_read_data(rd_q),
		.power_state(pst), .bank_open(bopen));
	always #25 clk = ~clk;
	// array answers one cycle after the read strobe
	always @(posedge clk) if (ren) rd_q <= {7'h0, rbank, rcol};
	task send(input sdpc_cmd_e c0, input logic b0, input logic [10:0] a0,
		input logic [15:0] d0, input logic [1:0] m0, input logic [1:0] m1,
		input sdpc_cmd_e c1);
		@(negedge clk);
		cmd = c0;
		bank = b0;
		addr = a0;
		wdata = d0;
		mask = m0;
		wdrive = (c0 == SDPC_CMD_WRITE);
		@(negedge clk);
		cmd = c1;
		mask = m1;
		wdrive = 1'b0;
		desel = (c1 != SDPC_CMD_NOP);
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#400000;
		mismatches++;
		wrap_up();
	end
	initial begin
		repeat (16) @(negedge clk);
		rst = 0;
		`CHK("bank_open", 2'h0, bopen)
		`CHK("power_state", SDPC_ST_RUN, pst)
		`CHK("data_oe", 16'h0, doe)
		send(SDPC_CMD_ACT, 1'h0, 11'h4c3, 16'h0, 2'h0, 2'h0, SDPC_CMD_NOP);
		send(SDPC_CMD_ACT, 1'h1, 11'h4c3, 16'h0, 2'h0, 2'h0, SDPC_CMD_NOP);
		`CHK("bank_open", 2'h3, bopen)
		for (int i = 0; i < 4; i++) begin
			{b, c, m, d} = rows[i];
			e = {{8{~m[1]}}, {8{~m[0]}}};
			send(SDPC_CMD_WRITE, b, {3'h5, c}, d, m, 2'h0, SDPC_CMD_NOP);
			`CHK("wr_en", 1'h1, aw.en)
			`CHK("byte_en", ~m, aw.en ? aw.byte_en : 2'h0)
			`CHK("wr_row", 11'h4c3, aw.row)
			`CHK("wr_col", c, aw.col)
			`CHK("wr_bank", b, aw.bank)
			`CHK("wr_data", d & e, aw.data & e)
			repeat (4) @(negedge clk);
			send(SDPC_CMD_READ, b, {3'h2, c}, 16'h0, 2'h0, m, SDPC_CMD_NOP);
			`CHK("rd_en", 1'h1, ren)
			`CHK("rd_row", 11'h4c3, rrow)
			`CHK("rd_col", c, rcol)
			`CHK("rd_bank", b, rbank)
			@(negedge clk);
			mask = 2'h0;
			@(negedge clk);
			`CHK("data_oe", e, doe)
			`CHK("data_out", {7'h0, b, c} & e, dout & e)
			repeat (5) @(negedge clk);
		end
		send(SDPC_CMD_PRE, 1'h0, 11'h000, 16'h0, 2'h0, 2'h0, SDPC_CMD_NOP);
		`CHK("bank_open", 2'h2, bopen)
		send(SDPC_CMD_PRE, 1'h0, 11'h400, 16'h0, 2'h0, 2'h0, SDPC_CMD_NOP);
		`CHK("bank_open", 2'h0, bopen)
		send(SDPC_CMD_WRITE, 1'h0, 11'h010, 16'h5555, 2'h0, 2'h0,
			SDPC_CMD_WRITE);
		@(negedge clk);
		`CHK("burst_col", 8'h11, aw.en ? aw.col : 8'h00)
		cmd = SDPC_CMD_NOP;
		desel = 1'b0;
		repeat (6) @(negedge clk);
		send(SDPC_CMD_WRITE, 1'h0, 11'h020, 16'h5a5a, 2'h0, 2'h0,
			SDPC_CMD_NOP);
		cke = 1'b0;
		@(negedge clk);
		`CHK("power_state", SDPC_ST_SUSP, pst)
		`CHK("susp_wr_en", 1'h0, aw.en)
		cke = 1'b1;
		repeat (2) @(negedge clk);
		`CHK("susp_col", 8'h21, aw.col)
		cmd = SDPC_CMD_STOP;
		@(negedge clk);
		cmd = SDPC_CMD_NOP;
		`CHK("stop_wr_en", 1'h0, aw.en)
		repeat (2) @(negedge clk);
		cke = 0;
		repeat (2) @(negedge clk);
		`CHK("power_state", SDPC_ST_PDOWN, pst)
		cke = 1;
		repeat (3) @(negedge clk);
		cmd = SDPC_CMD_REF;
		cke = 1'b0;
		@(negedge clk);
		cmd = SDPC_CMD_NOP;
		@(negedge clk);
		`CHK("power_state", SDPC_ST_SREF, pst)
		wrap_up();
	end
endmodule // tb_top
